// ### common/lcm_pkg.sv
// constants, register map and response codes for the load, current and mains protection block
package lcm_pkg;

  // ---------------------------------------------------------------
  // clock and qualify-time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned QUALIFY_UNIT_S = 1;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned CYCLES_PER_UNIT = (QUALIFY_UNIT_S * NS_PER_S) / CLK_PERIOD_NS;
  // current sensor secondary full scale, in milliamperes (the x/5 side)
  localparam int unsigned CT_SEC_SCALE_MA = 5000;

  // ---------------------------------------------------------------
  // response categories
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LCM_RESP_NONE = 3'h0,
    LCM_RESP_NOTIFY = 3'h1,
    LCM_RESP_WARN = 3'h2,
    LCM_RESP_ETRIP = 3'h3,
    LCM_RESP_SHUTDOWN = 3'h4
  } lcm_resp_t;

  // protection channel indices
  localparam int unsigned CH_OC = 0;
  localparam int unsigned CH_OL = 1;
  localparam int unsigned CH_UB = 2;
  localparam int unsigned CH_LL = 3;
  localparam int unsigned CH_PR = 4;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CT_CFG = 8'h00;
  localparam logic [7:0] OFS_OC_LIMIT = 8'h04;
  localparam logic [7:0] OFS_OL_LIMIT = 8'h08;
  localparam logic [7:0] OFS_UB_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_LL_CFG = 8'h10;
  localparam logic [7:0] OFS_DLY_OC = 8'h14;
  localparam logic [7:0] OFS_DLY_OL = 8'h18;
  localparam logic [7:0] OFS_DLY_UB = 8'h1c;
  localparam logic [7:0] OFS_DLY_LL = 8'h20;
  localparam logic [7:0] OFS_RESP = 8'h24;
  localparam logic [7:0] OFS_MAINS_CFG = 8'h28;
  localparam logic [7:0] OFS_VT = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_V_SCALED = 8'h34;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned POS_CT_PLACE = 16;
  localparam int unsigned POS_LL_EN = 0;
  localparam int unsigned POS_LL_TRIP = 8;
  localparam int unsigned POS_LL_RET = 16;
  localparam int unsigned POS_RESP_PR = 16;
  localparam int unsigned POS_MON_EN = 0;
  localparam int unsigned POS_THREE_PH = 1;
  localparam int unsigned POS_REV_DET = 2;
  localparam int unsigned POS_PARTIAL = 3;
  localparam int unsigned POS_VT_EN = 4;
  localparam int unsigned POS_VT_SEC = 16;
  localparam int unsigned POS_ST_PR = 12;
  localparam int unsigned POS_ST_COND = 16;
  localparam int unsigned POS_ST_FAIL = 20;
  localparam int unsigned POS_ST_REV = 21;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [12:0] RST_CT_RATIO = 13'h0096;
  localparam logic RST_CT_PLACE = 1'b0;
  localparam logic [13:0] RST_OC_LIMIT = 14'h0078;
  localparam logic [7:0] RST_OL_LIMIT = 8'h5a;
  localparam logic [7:0] RST_UB_LIMIT = 8'h05;
  localparam logic RST_LL_EN = 1'b0;
  localparam logic [6:0] RST_LL_TRIP = 7'h32;
  localparam logic [6:0] RST_LL_RET = 7'h33;
  localparam logic [11:0] RST_DLY = 12'h001;
  localparam logic RST_MON_EN = 1'b1;
  localparam logic RST_THREE_PH = 1'b1;
  localparam logic [14:0] RST_VT_PRI = 15'h0064;
  localparam logic [9:0] RST_VT_SEC = 10'h064;

endpackage

// ### rtl/lcm_protect.sv
// load, current and mains protection monitor with register port
`timescale 1ns/1ps
`default_nettype none

module lcm_protect #(
  parameter int unsigned P_CYCLES_PER_UNIT = lcm_pkg::CYCLES_PER_UNIT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [12:0] i_gen_cable_ma,
  input wire logic [12:0] i_load_cable_ma,
  input wire logic [7:0] i_load_pct,
  input wire logic [7:0] i_imbalance_pct,
  input wire logic [2:0] i_mains_phase_fail,
  input wire logic i_mains_order_ok,
  input wire logic [9:0] i_mains_v_sec,
  input wire logic [4:0] i_req_clear,
  output lcm_pkg::lcm_resp_t o_excess_amp_req,
  output lcm_pkg::lcm_resp_t o_excess_power_req,
  output lcm_pkg::lcm_resp_t o_phase_imbalance_req,
  output lcm_pkg::lcm_resp_t o_low_load_req,
  output logic o_phase_reversal_req,
  output logic o_phase_reversed,
  output logic o_mains_fail,
  output logic [24:0] o_grid_v_scaled
);
  import lcm_pkg::*;

  localparam int unsigned CNT_W = $clog2(P_CYCLES_PER_UNIT + 1);
  localparam logic [CNT_W-1:0] SUB_LAST = CNT_W'(P_CYCLES_PER_UNIT - 1);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [12:0] current_sensor_turns_ratio;
    logic current_sensor_placement;
    logic [13:0] excess_amp_limit;
    logic [7:0] excess_power_limit;
    logic [7:0] phase_imbalance_limit;
    logic low_load_en;
    logic [6:0] low_load_trip;
    logic [6:0] low_load_return;
    logic [3:0][11:0] qualify_time;
    logic [3:0][2:0] response;
    logic phase_reversal_response;
    logic mains_mon_en;
    logic grid_phase_count_select;
    logic reversal_detect_en;
    logic partial_healthy_en;
    logic grid_voltage_transformer_enable;
    logic [14:0] grid_vt_primary_value;
    logic [9:0] grid_vt_secondary_value;
    logic [3:0][CNT_W-1:0] sub_cnt;
    logic [3:0][11:0] unit_cnt;
    logic [3:0][2:0] req;
    logic pr_req;
    logic reversed;
    logic mains_fail;
    logic [24:0] v_scaled;
    logic [31:0] rdata;
  } lcm_state_t;

  lcm_state_t st_reg;
  lcm_state_t st_next;
  logic [3:0] cond;
  logic [3:0] fire;
  logic [12:0] sel_ma;
  logic [27:0] amp_scaled;
  logic [27:0] amp_limit_scaled;
  logic phase_fail_any;
  logic ll_withdraw;

  // clamp a zero qualify time to one unit
  function automatic logic [11:0] eff_time(input logic [11:0] t);
    eff_time = (t == 12'h000) ? 12'h001 : t;
  endfunction

  // unknown response codes behave as none
  function automatic logic [2:0] resp_ok(input logic [2:0] r);
    resp_ok = (r > LCM_RESP_SHUTDOWN) ? LCM_RESP_NONE : r;
  endfunction

  // -------------------------------------------------------------
  // protection conditions
  // -------------------------------------------------------------
  // current compared on the secondary side: sec_ma*ratio > limit*5000
  always_comb
  begin
    sel_ma = st_reg.current_sensor_placement ? i_load_cable_ma : i_gen_cable_ma;
    amp_scaled = 28'(sel_ma) * 28'(st_reg.current_sensor_turns_ratio);
    amp_limit_scaled = 28'(st_reg.excess_amp_limit) * 28'(CT_SEC_SCALE_MA);
    cond[CH_OC] = amp_scaled > amp_limit_scaled;
    cond[CH_OL] = i_load_pct > st_reg.excess_power_limit;
    cond[CH_UB] = i_imbalance_pct > st_reg.phase_imbalance_limit;
    ll_withdraw = (st_reg.response[CH_LL] == LCM_RESP_WARN) &&
                  (i_load_pct > 8'(st_reg.low_load_return));
    cond[CH_LL] = st_reg.low_load_en && (i_load_pct < 8'(st_reg.low_load_trip)) && !ll_withdraw;
  end

  // failed-phase vote for the mains
  always_comb
  begin
    if (!st_reg.grid_phase_count_select)
    begin
      phase_fail_any = i_mains_phase_fail[0];
    end
    else if (st_reg.partial_healthy_en)
    begin
      phase_fail_any = &i_mains_phase_fail;
    end
    else
    begin
      phase_fail_any = |i_mains_phase_fail;
    end
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    fire = 4'h0;
    // register writes
    if (i_wr)
    begin
      case (i_addr)
        OFS_CT_CFG:
        begin
          st_next.current_sensor_turns_ratio = i_wdata[12:0];
          st_next.current_sensor_placement = i_wdata[POS_CT_PLACE];
        end
        OFS_OC_LIMIT: st_next.excess_amp_limit = i_wdata[13:0];
        OFS_OL_LIMIT: st_next.excess_power_limit = i_wdata[7:0];
        OFS_UB_LIMIT: st_next.phase_imbalance_limit = i_wdata[7:0];
        OFS_LL_CFG:
        begin
          st_next.low_load_en = i_wdata[POS_LL_EN];
          st_next.low_load_trip = i_wdata[POS_LL_TRIP +: 7];
          st_next.low_load_return = i_wdata[POS_LL_RET +: 7];
        end
        OFS_DLY_OC: st_next.qualify_time[CH_OC] = i_wdata[11:0];
        OFS_DLY_OL: st_next.qualify_time[CH_OL] = i_wdata[11:0];
        OFS_DLY_UB: st_next.qualify_time[CH_UB] = i_wdata[11:0];
        OFS_DLY_LL: st_next.qualify_time[CH_LL] = i_wdata[11:0];
        OFS_RESP:
        begin
          // one 3-bit code per channel, on 4-bit boundaries
          st_next.response[CH_OC] = i_wdata[2:0];
          st_next.response[CH_OL] = i_wdata[6:4];
          st_next.response[CH_UB] = i_wdata[10:8];
          st_next.response[CH_LL] = i_wdata[14:12];
          st_next.phase_reversal_response = i_wdata[POS_RESP_PR];
        end
        OFS_MAINS_CFG:
        begin
          st_next.mains_mon_en = i_wdata[POS_MON_EN];
          st_next.grid_phase_count_select = i_wdata[POS_THREE_PH];
          st_next.reversal_detect_en = i_wdata[POS_REV_DET];
          st_next.partial_healthy_en = i_wdata[POS_PARTIAL];
          st_next.grid_voltage_transformer_enable = i_wdata[POS_VT_EN];
        end
        OFS_VT:
        begin
          st_next.grid_vt_primary_value = i_wdata[14:0];
          st_next.grid_vt_secondary_value = i_wdata[POS_VT_SEC +: 10];
        end
        default: st_next.rdata = st_reg.rdata; // read-only or unmapped: ignored
      endcase
    end
    // qualify timers: count whole units while the condition stays present
    for (int i = 0; i < 4; i++)
    begin
      if (!cond[i])
      begin
        st_next.sub_cnt[i] = '0;
        st_next.unit_cnt[i] = 12'h000;
      end
      else if (st_reg.unit_cnt[i] < eff_time(st_reg.qualify_time[i]))
      begin
        if (st_reg.sub_cnt[i] == SUB_LAST)
        begin
          st_next.sub_cnt[i] = '0;
          st_next.unit_cnt[i] = st_reg.unit_cnt[i] + 12'h001;
          fire[i] = (st_reg.unit_cnt[i] + 12'h001) == eff_time(st_reg.qualify_time[i]);
        end
        else
        begin
          st_next.sub_cnt[i] = st_reg.sub_cnt[i] + CNT_W'(1);
        end
      end
      // held request: set wins over clear
      if (fire[i] && (resp_ok(st_reg.response[i]) != LCM_RESP_NONE))
      begin
        st_next.req[i] = resp_ok(st_reg.response[i]);
      end
      else if (i_req_clear[i] || ((i == CH_LL) && ll_withdraw))
      begin
        st_next.req[i] = LCM_RESP_NONE;
      end
    end
    // mains supervision
    st_next.reversed = st_reg.reversal_detect_en && st_reg.grid_phase_count_select && !i_mains_order_ok;
    if (st_next.reversed && !st_reg.reversed && st_reg.phase_reversal_response)
    begin
      st_next.pr_req = 1'b1;
    end
    else if (i_req_clear[CH_PR])
    begin
      st_next.pr_req = 1'b0;
    end
    st_next.mains_fail = st_reg.mains_mon_en && phase_fail_any;
    // voltage scaling by the transformer ratio
    if (st_reg.grid_voltage_transformer_enable && (st_reg.grid_vt_secondary_value != 10'h000))
    begin
      st_next.v_scaled = 25'((25'(i_mains_v_sec) * 25'(st_reg.grid_vt_primary_value)) /
                             25'(st_reg.grid_vt_secondary_value));
    end
    else
    begin
      st_next.v_scaled = 25'(i_mains_v_sec);
    end
    // read data stands only in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        OFS_CT_CFG: st_next.rdata = 32'(st_reg.current_sensor_turns_ratio) |
                                    (32'(st_reg.current_sensor_placement) << POS_CT_PLACE);
        OFS_OC_LIMIT: st_next.rdata = 32'(st_reg.excess_amp_limit);
        OFS_OL_LIMIT: st_next.rdata = 32'(st_reg.excess_power_limit);
        OFS_UB_LIMIT: st_next.rdata = 32'(st_reg.phase_imbalance_limit);
        OFS_LL_CFG: st_next.rdata = 32'(st_reg.low_load_en) |
                                    (32'(st_reg.low_load_trip) << POS_LL_TRIP) |
                                    (32'(st_reg.low_load_return) << POS_LL_RET);
        OFS_DLY_OC: st_next.rdata = 32'(st_reg.qualify_time[CH_OC]);
        OFS_DLY_OL: st_next.rdata = 32'(st_reg.qualify_time[CH_OL]);
        OFS_DLY_UB: st_next.rdata = 32'(st_reg.qualify_time[CH_UB]);
        OFS_DLY_LL: st_next.rdata = 32'(st_reg.qualify_time[CH_LL]);
        OFS_RESP: st_next.rdata = 32'({1'b0, st_reg.response[CH_LL], 1'b0, st_reg.response[CH_UB],
                                       1'b0, st_reg.response[CH_OL], 1'b0, st_reg.response[CH_OC]}) |
                                  (32'(st_reg.phase_reversal_response) << POS_RESP_PR);
        OFS_MAINS_CFG: st_next.rdata = 32'({st_reg.grid_voltage_transformer_enable, st_reg.partial_healthy_en,
                                            st_reg.reversal_detect_en, st_reg.grid_phase_count_select,
                                            st_reg.mains_mon_en});
        OFS_VT: st_next.rdata = 32'(st_reg.grid_vt_primary_value) |
                                (32'(st_reg.grid_vt_secondary_value) << POS_VT_SEC);
        OFS_STATUS: st_next.rdata = 32'(st_reg.req) | (32'(st_reg.pr_req) << POS_ST_PR) |
                                    (32'(cond) << POS_ST_COND) | (32'(st_reg.mains_fail) << POS_ST_FAIL) |
                                    (32'(st_reg.reversed) << POS_ST_REV);
        OFS_V_SCALED: st_next.rdata = 32'(st_reg.v_scaled);
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_reg <= '0;
      st_reg.current_sensor_turns_ratio <= RST_CT_RATIO;
      st_reg.current_sensor_placement <= RST_CT_PLACE;
      st_reg.excess_amp_limit <= RST_OC_LIMIT;
      st_reg.excess_power_limit <= RST_OL_LIMIT;
      st_reg.phase_imbalance_limit <= RST_UB_LIMIT;
      st_reg.low_load_en <= RST_LL_EN;
      st_reg.low_load_trip <= RST_LL_TRIP;
      st_reg.low_load_return <= RST_LL_RET;
      st_reg.qualify_time <= {4{RST_DLY}};
      st_reg.mains_mon_en <= RST_MON_EN;
      st_reg.grid_phase_count_select <= RST_THREE_PH;
      st_reg.grid_vt_primary_value <= RST_VT_PRI;
      st_reg.grid_vt_secondary_value <= RST_VT_SEC;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign o_rdata = st_reg.rdata;
  assign o_excess_amp_req = lcm_resp_t'(st_reg.req[CH_OC]);
  assign o_excess_power_req = lcm_resp_t'(st_reg.req[CH_OL]);
  assign o_phase_imbalance_req = lcm_resp_t'(st_reg.req[CH_UB]);
  assign o_low_load_req = lcm_resp_t'(st_reg.req[CH_LL]);
  assign o_phase_reversal_req = st_reg.pr_req;
  assign o_phase_reversed = st_reg.reversed;
  assign o_mains_fail = st_reg.mains_fail;
  assign o_grid_v_scaled = st_reg.v_scaled;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  property p_oc_code;
    (o_excess_amp_req != $past(o_excess_amp_req)) && (o_excess_amp_req != LCM_RESP_NONE) |->
      (o_excess_amp_req == $past(resp_ok(st_reg.response[CH_OC])));
  endproperty
  a_oc_code: assert property (p_oc_code) else $error("over-current request differs from response");

  property p_oc_qualified;
    $rose(st_reg.req[CH_OC] != 3'h0) |-> $past(cond[CH_OC]) && ($past(st_reg.unit_cnt[CH_OC]) ==
      eff_time($past(st_reg.qualify_time[CH_OC])) - 12'h001);
  endproperty
  a_oc_qualified: assert property (p_oc_qualified) else $error("over-current request without qualify");

  property p_timer_restart;
    !cond[CH_OL] |=> (st_reg.unit_cnt[CH_OL] == 12'h000) && (st_reg.sub_cnt[CH_OL] == '0);
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("overload timer kept counting");

  property p_req_held;
    (st_reg.req[CH_UB] != 3'h0) && !i_req_clear[CH_UB] && !fire[CH_UB] |=> $stable(st_reg.req[CH_UB]);
  endproperty
  a_req_held: assert property (p_req_held) else $error("imbalance request dropped uncleared");

  property p_ll_disabled;
    !st_reg.low_load_en |-> !cond[CH_LL] && !fire[CH_LL];
  endproperty
  a_ll_disabled: assert property (p_ll_disabled) else $error("low load evaluated while disabled");

  property p_ll_return;
    ll_withdraw && !i_req_clear[CH_LL] |=> o_low_load_req == LCM_RESP_NONE;
  endproperty
  a_ll_return: assert property (p_ll_return) else $error("low-load warning kept above return");

  property p_mon_off;
    !st_reg.mains_mon_en ##1 !st_reg.mains_mon_en |-> !o_mains_fail;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("mains failure while monitoring off");

  property p_reversal;
    st_reg.reversal_detect_en && st_reg.grid_phase_count_select && !i_mains_order_ok |=> o_phase_reversed;
  endproperty
  a_reversal: assert property (p_reversal) else $error("phase reversal not flagged");

  property p_partial;
    st_reg.grid_phase_count_select && st_reg.partial_healthy_en && !(&i_mains_phase_fail) |=> !o_mains_fail;
  endproperty
  a_partial: assert property (p_partial) else $error("partial phase loss declared as failure");

  c_oc_fire: cover property (fire[CH_OC] && (st_reg.response[CH_OC] == LCM_RESP_ETRIP));
  c_ll_warn: cover property (fire[CH_LL] ##[1:20] ll_withdraw);
  c_mains_fail: cover property ($rose(o_mains_fail));
  c_reversal: cover property ($rose(o_phase_reversal_req));

endmodule

`default_nettype wire

// ### dv/lcm_alarm_model.sv
// alarm handler model that acknowledges held protection requests
`timescale 1ns/1ps
`default_nettype none
module lcm_alarm_model
  import lcm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ack_en,
  input wire lcm_pkg::lcm_resp_t i_oc,
  input wire lcm_pkg::lcm_resp_t i_ol,
  input wire lcm_pkg::lcm_resp_t i_ub,
  input wire lcm_pkg::lcm_resp_t i_ll,
  input wire logic i_pr,
  output logic [4:0] o_req_clear
);
  // one-cycle clear pulse per pending request, only while acking is allowed
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_req_clear <= 5'h00;
    else if (i_ack_en)
      o_req_clear <= {i_pr, i_ll != 0, i_ub != 0, i_ol != 0, i_oc != 0} & ~o_req_clear;
    else
      o_req_clear <= 5'h00;
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the protection monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lcm_pkg::*;
  localparam int P = 4;
  logic i_clk_sys = 0;
  logic i_rst_b = 0;
  logic [7:0] addr = 0, lpct = 8'd60, imb = 0;
  logic [31:0] wdata = 0, rdata;
  logic wr = 0, rd = 0, ack = 0, ord_ok = 1, prq, rev, fail;
  logic [12:0] gen = 0, ldc = 0;
  logic [2:0] pfail = 0;
  logic [9:0] vsec = 10'd230;
  logic [4:0] clr;
  logic [24:0] vsc;
  logic [15:0] lfsr = 16'd16015;
  lcm_resp_t oc, ol, ub, ll;
  int err_total = 0, check_count = 0, cyc = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  lcm_protect #(.P_CYCLES_PER_UNIT(P)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_gen_cable_ma(gen), .i_load_cable_ma(ldc),
    .i_load_pct(lpct), .i_imbalance_pct(imb), .i_mains_phase_fail(pfail), .i_mains_order_ok(ord_ok),
    .i_mains_v_sec(vsec), .i_req_clear(clr), .o_excess_amp_req(oc), .o_excess_power_req(ol),
    .o_phase_imbalance_req(ub), .o_low_load_req(ll), .o_phase_reversal_req(prq), .o_phase_reversed(rev),
    .o_mains_fail(fail), .o_grid_v_scaled(vsc));
  lcm_alarm_model u_alarm (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ack_en(ack), .i_oc(oc), .i_ol(ol),
    .i_ub(ub), .i_ll(ll), .i_pr(prq), .o_req_clear(clr));
  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk_sys);
    wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge i_clk_sys);
    rd <= 1;
    addr <= a;
    @(posedge i_clk_sys);
    rd <= 0;
    #1;
    chk(rdata & mask, exp);
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // oc limit 120 A at ratio 150: over when ma*150 > 120*5000
  function automatic logic [31:0] live_exp(input logic [12:0] ma, input logic [7:0] l, input logic [7:0] u);
    live_exp = {13'h0, u > 8'd5, l > 8'd90, ma * 150 > 120 * CT_SEC_SCALE_MA, 16'h0};
  endfunction
  // drive channel condition on or just off its limit; low load goes to 30 or 60 against trip 50
  task automatic cond(input int ch, input bit on);
    @(posedge i_clk_sys);
    case (ch)
      0: gen <= on ? 13'd4001 : 13'd4000;
      1: lpct <= on ? 8'd91 : 8'd90;
      2: imb <= on ? 8'd6 : 8'd5;
      default: lpct <= on ? 8'd30 : 8'd60;
    endcase
  endtask
  function automatic logic [2:0] req(input int ch);
    req = ch == 0 ? oc : ch == 1 ? ol : ch == 2 ? ub : ll;
  endfunction
  task automatic run(input int ch, input logic [2:0] code);
    wreg(OFS_RESP, {29'h0, code} << (4 * ch));
    // drop the condition one clock edge before expiry, then restart it
    cond(ch, 1);
    tick(P - 2);
    chk(req(ch), 0);
    cond(ch, 0);
    cond(ch, 1);
    tick(P - 1);
    chk(req(ch), 0);
    tick(1);
    chk(req(ch), code);
    tick(5);
    chk(req(ch), code);
    if (ch == 3 && code == LCM_RESP_WARN)
    begin
      cond(3, 0);
      tick(3);
      chk(req(3), 0);
    end
    else
    begin
      ack <= 1;
      tick(4);
      chk(req(ch), 0);
      ack <= 0;
      cond(ch, 0);
    end
    tick(2);
  endtask
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial
  begin
    tick(8);
    i_rst_b <= 1;
    rreg(OFS_CT_CFG, 32'hffffffff, 32'h00000096);
    rreg(OFS_OC_LIMIT, 32'hffffffff, 32'h00000078);
    rreg(OFS_OL_LIMIT, 32'hffffffff, 32'h0000005a);
    rreg(OFS_UB_LIMIT, 32'hffffffff, 32'h00000005);
    rreg(OFS_LL_CFG, 32'hffffffff, 32'h00333200);
    rreg(OFS_DLY_LL, 32'hffffffff, 32'h00000001);
    rreg(OFS_RESP, 32'hffffffff, 32'h00000000);
    rreg(OFS_MAINS_CFG, 32'hffffffff, 32'h00000003);
    rreg(OFS_VT, 32'hffffffff, 32'h00640064);
    rreg(8'h40, 32'hffffffff, 32'h0);
    chk(vsc, 25'd230);
    wreg(OFS_RESP, 32'h4000);
    cond(3, 1);
    tick(2 * P + 3);
    chk(ll, 0);
    wreg(OFS_RESP, 32'h5);
    cond(0, 1);
    tick(2 * P + 3);
    chk(oc, 0);
    cond(0, 0);
    cond(3, 0);
    wreg(OFS_LL_CFG, 32'h00333201);
    for (int k = 0; k < 8; k++)
      run(k % 4, 3'((k % 4 + 2 * (k / 4)) % 4 + 1));
    wreg(OFS_LL_CFG, 32'h00333200);
    wreg(OFS_RESP, 32'h0);
    for (int k = 0; k < 20; k++)
    begin
      lfsr = nxt(lfsr);
      gen <= lfsr[12:0];
      lpct <= {1'b0, lfsr[7:1]};
      imb <= lfsr[15:8] & 8'h0f;
      tick(2);
      rreg(OFS_STATUS, 32'h00070000, live_exp(gen, lpct, imb));
    end
    gen <= 0;
    ldc <= 13'd4001;
    wreg(OFS_CT_CFG, 32'h00010096);
    rreg(OFS_STATUS, 32'h00010000, 32'h00010000);
    pfail <= 3'b001;
    tick(2);
    chk(fail, 1);
    wreg(OFS_MAINS_CFG, 32'h0b);
    tick(2);
    chk(fail, 0);
    pfail <= 3'b111;
    tick(2);
    chk(fail, 1);
    wreg(OFS_MAINS_CFG, 32'h0a);
    tick(2);
    chk(fail, 0);
    pfail <= 3'b110;
    wreg(OFS_MAINS_CFG, 32'h01);
    tick(2);
    chk(fail, 0);
    wreg(OFS_MAINS_CFG, 32'h07);
    wreg(OFS_RESP, 32'h10000);
    ord_ok <= 0;
    tick(3);
    chk({rev, prq}, 2'b11);
    ack <= 1;
    tick(3);
    chk(prq, 0);
    wreg(OFS_MAINS_CFG, 32'h13);
    wreg(OFS_VT, 32'h006400c8);
    tick(2);
    chk(vsc, 25'd460);
    end_sim();
  end
endmodule
`default_nettype wire
